// >>> io_slot_remap_regs.svh
// constants of the slot remap table: record identity, entry codes, sizes
// assumes inclusion by bare name from the package and the design files
`ifndef IO_SLOT_REMAP_REGS_SVH
`define IO_SLOT_REMAP_REGS_SVH

`define REC_NUM      8'h7F
`define REC_LEN      7'h40
`define REC_LAST     7'h3F
`define SLOT_LAST    6'h3F
`define SLOT_FIRST   6'h00
`define MAP_IGNORE   8'h00
`define MAP_MIN      8'h01
`define MAP_MAX      8'h40
`define MAP_VIRTUAL  8'hFF
`define ZERO_BYTE    8'h00
`define CNT_STEP     7'h01
`define SLOT_STEP    6'h01
`define COPY_CYCLES  65

`endif

// >>> io_slot_remap_pkg.sv
// types shared by the slot remap table and its retentive store
// assumes io_slot_remap_regs.svh is reachable on the include path
`include "io_slot_remap_regs.svh"

package io_slot_remap_pkg;

   typedef enum logic [1:0] {
      CLS_IGNORE = 2'h0,
      CLS_PHYS   = 2'h1,
      CLS_VIRT   = 2'h2,
      CLS_BAD    = 2'h3
   } entry_cls_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_RECV = 3'h2,
      ST_COPY = 3'h4
   } state_t;

   // one byte of a record write stream
   typedef struct packed {
      logic       valid;
      logic       first;
      logic       last;
      logic [7:0] rec;
      logic [7:0] data;
   } wr_in_t;

   typedef struct packed {
      logic       valid;
      logic       ok;
      logic       err_rec;
      logic       err_len;
      logic       err_value;
      logic       saved;
   } wr_rsp_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] rec;
      logic [5:0] idx;
   } rd_in_t;

   typedef struct packed {
      logic       valid;
      logic       ok;
      logic [7:0] data;
   } rd_rsp_t;

   // user program access to a target slot (index = slot - 1)
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [5:0] slot;
      logic [7:0] data;
   } io_req_t;

   typedef struct packed {
      logic       valid;
      logic       virt;
      logic       ignored;
      logic [7:0] data;
   } io_rsp_t;

   // access to a physical slot on the backplane (index = slot - 1)
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [5:0] slot;
      logic [7:0] data;
   } bp_req_t;

   function automatic entry_cls_t classify(input logic [7:0] e);
      if (e == `MAP_IGNORE)
         return CLS_IGNORE;
      else if (e == `MAP_VIRTUAL)
         return CLS_VIRT;
      else if (e >= `MAP_MIN && e <= `MAP_MAX)
         return CLS_PHYS;
      else
         return CLS_BAD;
   endfunction

endpackage

// >>> remap_store.sv
// retentive store of the active 64-entry remap record
// assumes the array sits in non-volatile cells; only power-on clears the valid flag
`timescale 1ns/100ps
`default_nettype none

module remap_store
   import io_slot_remap_pkg::*;
(
   input  wire logic       i_sys_clk,
   input  wire logic       i_por_n,
   input  wire logic       i_wr_en,
   input  wire logic [5:0] i_wr_addr,
   input  wire logic [7:0] i_wr_data,
   input  wire logic       i_commit,
   input  wire logic [5:0] i_rd_a_addr,
   input  wire logic [5:0] i_rd_b_addr,
   input  wire logic [5:0] i_rd_c_addr,
   output logic      [7:0] o_rd_a_data,
   output logic      [7:0] o_rd_b_data,
   output logic      [7:0] o_rd_c_data,
   output logic            o_valid
);

   logic [7:0] mem_q [64];
   logic       valid_q;

   // no reset on the contents: they must outlive a controller reset
   always_ff @(posedge i_sys_clk) begin
      if (i_wr_en)
         mem_q[i_wr_addr] <= i_wr_data;
   end

   always_ff @(posedge i_sys_clk or negedge i_por_n) begin
      if (!i_por_n)
         valid_q <= 1'b0;
      else if (i_commit)
         valid_q <= 1'b1;
   end

   assign o_rd_a_data = mem_q[i_rd_a_addr];
   assign o_rd_b_data = mem_q[i_rd_b_addr];
   assign o_rd_c_data = mem_q[i_rd_c_addr];
   assign o_valid     = valid_q;

endmodule

`default_nettype wire

// >>> io_slot_remap_table.sv
// slot remap table: record 0x7F intake, retentive commit, target-to-actual routing
// assumes all inputs come from logic on i_sys_clk; the store is powered apart
//
// Functional notes
// - remapping stays off until the enable input i_slot_remap_feature is set.
// - configuration is one 64-byte record 0x7F; byte n serves target slot n+1.
// - entry 0x00 ignores the target slot, leaving a gap.
// - entries 0x01..0x40 route to that physical slot number.
// - entry 0xFF marks the target slot as a virtual module.
// - virtual module inputs always read zero.
// - writes to a virtual module vanish without any effect.
// - when active, missing module outputs are dropped and inputs read zero.
// - when active, startup reports no target/actual layout mismatch.
// - the record is held in retentive storage; here it outlives a controller reset, but power-on clears its valid flag.
// - reads may return parts; writes accepted only as a full record.
// - a valid record is saved only if it differs from the stored one.
// - a successful write is stored and applied at once, no restart.
`timescale 1ns/100ps
`default_nettype none
`include "io_slot_remap_regs.svh"

module io_slot_remap_table
   import io_slot_remap_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_por_n,
   input  wire logic        i_slot_remap_feature,
   input  wire wr_in_t      i_wr,
   input  wire rd_in_t      i_rd,
   input  wire io_req_t     i_io,
   input  wire logic        i_bp_rvalid,
   input  wire logic [7:0]  i_bp_rdata,
   input  wire logic        i_startup_check,
   input  wire logic [63:0] i_target_used,
   input  wire logic [63:0] i_present,
   output wr_rsp_t          o_wr_rsp,
   output rd_rsp_t          o_rd_rsp,
   output logic             o_io_ready,
   output io_rsp_t          o_io_rsp,
   output bp_req_t          o_bp_req,
   output logic             o_nv_commit,
   output logic             o_remap_active,
   output logic             o_layout_mismatch
);

   state_t     state_q;
   logic [6:0] cnt_q;
   logic [5:0] copy_q;
   logic       bad_q;
   logic       diff_q;
   logic       busy_q;
   logic [7:0] shadow_q [64];
   logic [7:0] entry_a;
   logic [7:0] entry_b;
   logic [7:0] entry_c;
   logic       store_valid;
   logic       remap_active;
   entry_cls_t cls_a;
   logic       accept;
   logic       routed;
   logic       byte_in;
   logic       rec_end;
   logic       len_ok;
   logic       bad_now;
   logic       diff_now;
   logic       enter_copy;
   logic       copy_last;
   logic       busy_d;

   remap_store u_store (
      .i_sys_clk   (i_sys_clk),
      .i_por_n     (i_por_n),
      .i_wr_en     (state_q == ST_COPY),
      .i_wr_addr   (copy_q),
      .i_wr_data   (shadow_q[copy_q]),
      .i_commit    (copy_last),
      .i_rd_a_addr (i_io.slot),
      // in idle the count is stale, so the header byte is compared against entry 0
      .i_rd_b_addr ((state_q == ST_RECV) ? cnt_q[5:0] : `SLOT_FIRST),
      .i_rd_c_addr (i_rd.idx),
      .o_rd_a_data (entry_a),
      .o_rd_b_data (entry_b),
      .o_rd_c_data (entry_c),
      .o_valid     (store_valid)
   );

   assign remap_active = i_slot_remap_feature && store_valid;
   assign cls_a        = classify(entry_a);
   assign accept       = i_io.valid && o_io_ready;
   // with remapping off every target slot passes straight through
   assign routed       = !remap_active || (cls_a == CLS_PHYS);

   // record intake
   assign byte_in    = (state_q == ST_RECV) && i_wr.valid;
   assign rec_end    = byte_in && i_wr.last;
   assign len_ok     = (cnt_q == `REC_LAST);
   assign bad_now    = bad_q || (classify(i_wr.data) == CLS_BAD);
   assign diff_now   = diff_q || (cnt_q < `REC_LEN && i_wr.data != entry_b) || !store_valid;
   assign enter_copy = rec_end && len_ok && !bad_now && diff_now;
   assign copy_last  = (state_q == ST_COPY) && (copy_q == `SLOT_LAST);

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn)
         state_q <= ST_IDLE;
      else begin
         case (state_q)
            ST_IDLE: begin
               if (i_wr.valid && i_wr.first && i_wr.rec == `REC_NUM)
                  state_q <= i_wr.last ? ST_IDLE : ST_RECV;
            end
            ST_RECV: begin
               if (enter_copy)
                  state_q <= ST_COPY;
               else if (rec_end)
                  state_q <= ST_IDLE;
            end
            ST_COPY: begin
               if (copy_last)
                  state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // the first byte arrives with the header, so the count starts at one
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_q  <= '0;
         bad_q  <= 1'b0;
         diff_q <= 1'b0;
      end else if (state_q == ST_IDLE && i_wr.valid && i_wr.first) begin
         cnt_q  <= `CNT_STEP;
         bad_q  <= classify(i_wr.data) == CLS_BAD;
         diff_q <= (i_wr.data != entry_b) || !store_valid;
      end else if (byte_in) begin
         if (cnt_q < `REC_LEN)
            cnt_q <= cnt_q + `CNT_STEP;
         bad_q  <= bad_now;
         diff_q <= diff_now;
      end
   end

   // shadow keeps the old mapping live until the whole record checks out
   always_ff @(posedge i_sys_clk) begin
      if (state_q == ST_IDLE && i_wr.valid && i_wr.first)
         shadow_q[`SLOT_FIRST] <= i_wr.data;
      else if (byte_in && cnt_q < `REC_LEN)
         shadow_q[cnt_q[5:0]] <= i_wr.data;
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn)
         copy_q <= `SLOT_FIRST;
      else if (state_q == ST_COPY)
         copy_q <= copy_q + `SLOT_STEP;
      else
         copy_q <= `SLOT_FIRST;
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_wr_rsp    <= '0;
         o_nv_commit <= 1'b0;
      end else begin
         o_wr_rsp    <= '0;
         o_nv_commit <= copy_last;
         if (state_q == ST_IDLE && i_wr.valid && i_wr.first) begin
            if (i_wr.rec != `REC_NUM) begin
               o_wr_rsp.valid   <= 1'b1;
               o_wr_rsp.err_rec <= 1'b1;
            end else if (i_wr.last) begin
               o_wr_rsp.valid   <= 1'b1;
               o_wr_rsp.err_len <= 1'b1;
            end
         end else if (rec_end && !enter_copy) begin
            o_wr_rsp.valid     <= 1'b1;
            o_wr_rsp.ok        <= len_ok && !bad_now;
            o_wr_rsp.err_len   <= !len_ok;
            o_wr_rsp.err_value <= bad_now;
         end else if (copy_last) begin
            o_wr_rsp.valid <= 1'b1;
            o_wr_rsp.ok    <= 1'b1;
            o_wr_rsp.saved <= 1'b1;
         end
      end
   end

   // record read: any byte of the active record, zero before first commit
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn)
         o_rd_rsp <= '0;
      else begin
         o_rd_rsp.valid <= i_rd.valid;
         o_rd_rsp.ok    <= i_rd.valid && i_rd.rec == `REC_NUM;
         o_rd_rsp.data  <= (i_rd.rec == `REC_NUM && store_valid) ? entry_c : `ZERO_BYTE;
      end
   end

   // target slot access; the copy phase holds it off so no half record is used
   assign busy_d = (accept && routed && !i_io.write) ? 1'b1 :
                   (i_bp_rvalid ? 1'b0 : busy_q);

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         busy_q     <= 1'b0;
         o_io_ready <= 1'b0;
      end else begin
         busy_q     <= busy_d;
         o_io_ready <= !busy_d && !enter_copy && !(state_q == ST_COPY && !copy_last);
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn)
         o_bp_req <= '0;
      else begin
         o_bp_req.valid <= accept && routed;
         o_bp_req.write <= i_io.write;
         o_bp_req.slot  <= remap_active ? 6'(entry_a - `MAP_MIN) : i_io.slot;
         o_bp_req.data  <= i_io.data;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn)
         o_io_rsp <= '0;
      else begin
         o_io_rsp <= '0;
         if (accept && !routed) begin
            o_io_rsp.valid   <= 1'b1;
            o_io_rsp.virt    <= cls_a == CLS_VIRT;
            o_io_rsp.ignored <= cls_a != CLS_VIRT;
            o_io_rsp.data    <= `ZERO_BYTE;
         end else if (accept && i_io.write) begin
            o_io_rsp.valid <= 1'b1;
         end else if (busy_q && i_bp_rvalid) begin
            o_io_rsp.valid <= 1'b1;
            o_io_rsp.data  <= i_bp_rdata;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_layout_mismatch <= 1'b0;
         o_remap_active    <= 1'b0;
      end else begin
         o_remap_active <= remap_active;
         if (i_startup_check)
            o_layout_mismatch <= !remap_active && ((i_target_used & ~i_present) != '0);
      end
   end

   a_off_identity : assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      accept && !remap_active |=> o_bp_req.valid && o_bp_req.slot == $past(i_io.slot))
      else $error("pass-through slot changed while remapping off");
   a_phys_route : assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      accept && remap_active && cls_a == CLS_PHYS
      |=> o_bp_req.valid && o_bp_req.slot == $past(6'(entry_a - `MAP_MIN)))
      else $error("mapped slot routed to wrong physical slot");
   a_virt_zero : assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      accept && remap_active && cls_a == CLS_VIRT && !i_io.write
      |=> o_io_rsp.valid && o_io_rsp.virt && o_io_rsp.data == `ZERO_BYTE)
      else $error("virtual module input not zero");
   a_virt_drop : assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      accept && remap_active && cls_a == CLS_VIRT |=> !o_bp_req.valid)
      else $error("virtual module access reached backplane");
   a_ignore_gap : assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      accept && remap_active && cls_a == CLS_IGNORE |=> !o_bp_req.valid && o_io_rsp.ignored)
      else $error("ignored slot reached backplane");
   a_no_mismatch : assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      i_startup_check && remap_active |=> !o_layout_mismatch)
      else $error("mismatch reported with remapping active");
   a_bad_reject : assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      rec_end && bad_now |=> state_q == ST_IDLE && o_wr_rsp.err_value && !o_wr_rsp.ok)
      else $error("record with invalid entry not rejected");
   a_short_reject : assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      rec_end && !len_ok |=> o_wr_rsp.err_len ##1 !o_nv_commit)
      else $error("incomplete record accepted");
   a_same_nosave : assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      rec_end && len_ok && !bad_now && !diff_now |=> o_wr_rsp.ok && !o_wr_rsp.saved
      && state_q == ST_IDLE)
      else $error("unchanged record was saved");
   a_commit_time : assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      enter_copy |-> ##`COPY_CYCLES o_nv_commit && o_wr_rsp.saved && store_valid)
      else $error("commit not seen after copy");

endmodule

`default_nettype wire

// >>> bp_model.sv
// backplane stand-in: keeps one byte for each physical slot and answers reads late
// assumes requests are one-cycle pulses on the table's clock
`timescale 1ns/100ps
`default_nettype none

module bp_model
   import io_slot_remap_pkg::*;
(
   input  wire logic    i_sys_clk,
   input  wire logic    i_resetn,
   input  wire bp_req_t i_req,
   output logic         o_rvalid,
   output logic [7:0]   o_rdata
);
   logic [7:0] mem_q [64];
   logic [5:0] slot_q;
   logic [1:0] wait_q;
   logic [7:0] turn_q;
   logic       busy_q;

   always_ff @(posedge i_sys_clk) begin
      if (i_req.valid && i_req.write)
         mem_q[i_req.slot] <= i_req.data;
   end

   // delay of 0 to 3 cycles so a blocked read is held for varying spans
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         busy_q   <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata  <= 8'h00;
         slot_q   <= 6'h00;
         wait_q   <= 2'h0;
         turn_q   <= 8'h00;
      end else begin
         turn_q   <= turn_q + 8'h01;
         o_rvalid <= busy_q && wait_q == 2'h0;
         // outside an answer the data changes every cycle, never a stale byte
         o_rdata  <= (busy_q && wait_q == 2'h0) ? mem_q[slot_q] : turn_q;
         if (i_req.valid && !i_req.write) begin
            busy_q <= 1'b1;
            slot_q <= i_req.slot;
            wait_q <= turn_q[1:0];
         end else if (busy_q) begin
            if (wait_q == 2'h0)
               busy_q <= 1'b0;
            else
               wait_q <= wait_q - 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench of the slot remap table: records, routing, refusals, resets
// assumes bp_model stands in for the backplane modules
`timescale 1ns/100ps
`default_nettype none

module tb import io_slot_remap_pkg::*;;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        por_n = 1'b0;
   logic        feat = 1'b0;
   logic        start = 1'b0;
   logic [63:0] used = '0;
   logic [63:0] pres = '0;
   wr_in_t      wr = '0;
   rd_in_t      rd = '0;
   io_req_t     io = '0;
   logic        bp_rvalid;
   logic [7:0]  bp_rdata;
   wr_rsp_t     wr_rsp;
   rd_rsp_t     rd_rsp;
   io_rsp_t     io_rsp;
   bp_req_t     bp_req;
   logic        io_ready, commit, active, mism, ok;
   int          errors = 0;
   int          total_checks = 0;
   int          n_wr = 0, n_io = 0, n_bp = 0, n_cm = 0, idx;
   wr_rsp_t     l_wr;
   io_rsp_t     l_io;
   bp_req_t     l_bp;
   logic [31:0] seed = 32'h0000_431C;
   logic [7:0]  ent [64];
   logic [7:0]  act [64];
   logic [7:0]  shd [64];
   logic [7:0]  bad [3];

   always #5 clk = ~clk;

   io_slot_remap_table dut (.i_sys_clk(clk), .i_resetn(rstn), .i_por_n(por_n),
      .i_slot_remap_feature(feat), .i_wr(wr), .i_rd(rd), .i_io(io), .i_bp_rvalid(bp_rvalid),
      .i_bp_rdata(bp_rdata), .i_startup_check(start), .i_target_used(used),
      .i_present(pres), .o_wr_rsp(wr_rsp), .o_rd_rsp(rd_rsp), .o_io_ready(io_ready),
      .o_io_rsp(io_rsp), .o_bp_req(bp_req), .o_nv_commit(commit), .o_remap_active(active),
      .o_layout_mismatch(mism));
   bp_model bp (.i_sys_clk(clk), .i_resetn(rstn), .i_req(bp_req), .o_rvalid(bp_rvalid),
      .o_rdata(bp_rdata));

   // outputs stand one cycle, so they are caught at every edge
   always @(posedge clk) begin
      if (wr_rsp.valid === 1'b1) begin
         l_wr = wr_rsp;
         n_wr++;
      end
      if (io_rsp.valid === 1'b1) begin
         l_io = io_rsp;
         n_io++;
      end
      if (bp_req.valid === 1'b1) begin
         l_bp = bp_req;
         n_bp++;
      end
      if (commit === 1'b1)
         n_cm++;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic c, input string m);
      total_checks++;
      if (c !== 1'b1) begin
         errors++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic wait_cnt(ref int cnt, input int base);
      for (int i = 0; i < 100 && cnt == base; i++)
         @(negedge clk);
      chk(cnt != base, "no answer");
   endtask

   task automatic wr_rec(input logic [7:0] rec, input int n, input logic [3:0] e, input logic sv);
      int b, c;
      b = n_wr;
      c = n_cm;
      for (int k = 0; k < n; k++) begin
         @(posedge clk);
         wr <= '{valid: 1'b1, first: k == 0, last: k == n - 1, rec: rec, data: ent[k % 64]};
      end
      @(posedge clk);
      wr <= '0;
      wait_cnt(n_wr, b);
      repeat (2) @(negedge clk);
      ok = {l_wr.ok, l_wr.err_rec, l_wr.err_len, l_wr.err_value} === e;
      chk(ok && l_wr.saved === sv && n_cm - c == int'(sv), "write answer");
      if (sv)
         act = ent;
   endtask

   task automatic rd_all(input logic [7:0] rec);
      for (int k = 0; k <= 64; k++) begin
         @(posedge clk);
         rd <= '{valid: k < 64, rec: rec, idx: k[5:0]};
         if (k > 0) begin
            @(negedge clk);
            ok = rd_rsp.ok === (rec == 8'h7F);
            ok = ok && rd_rsp.data === (rec == 8'h7F ? act[k - 1] : 8'h00);
            chk(rd_rsp.valid === 1'b1 && ok, "read back");
         end
      end
   endtask

   task automatic acc(input logic w, input logic [5:0] s, input logic [7:0] d);
      int bi, bb;
      logic [7:0] e, a;
      // with the feature off every target slot passes to the same physical slot
      e = (feat === 1'b1) ? act[s] : 8'(s) + 8'h01;
      a = e - 8'h01;
      for (int i = 0; i < 20 && io_ready !== 1'b1; i++)
         @(negedge clk);
      bi = n_io;
      bb = n_bp;
      @(posedge clk);
      io <= '{valid: 1'b1, write: w, slot: s, data: d};
      @(posedge clk);
      io <= '0;
      wait_cnt(n_io, bi);
      if (e == 8'h00 || e == 8'hFF) begin
         ok = n_bp == bb && l_io.virt === (e == 8'hFF) && l_io.ignored === (e == 8'h00);
         chk(ok && l_io.data === 8'h00, "stand-in slot access");
      end else begin
         ok = n_bp == bb + 1 && l_bp.write === w && l_bp.slot === a[5:0];
         ok = ok && (w ? l_bp.data === d : l_io.data === shd[a[5:0]]);
         chk(ok, "routed slot access");
         if (w)
            shd[a[5:0]] = d;
      end
   endtask

   task automatic startup(input logic quiet);
      logic [63:0] u, p;
      u = {rnd(), rnd()} | 64'h0000_0000_0000_0001;
      p = {rnd(), rnd()} & ~64'h0000_0000_0000_0001;
      @(posedge clk);
      used <= u;
      pres <= p;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      @(negedge clk);
      chk(mism === (quiet ? 1'b0 : |(u & ~p)), "layout mismatch");
   endtask

   task automatic pulse(input logic por);
      @(posedge clk);
      if (por)
         por_n <= 1'b0;
      else
         rstn <= 1'b0;
      repeat (2) @(posedge clk);
      por_n <= 1'b1;
      rstn <= 1'b1;
      repeat (3) @(negedge clk);
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      print_verdict();
   end

   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      por_n <= 1'b1;
      feat <= 1'b1;
      repeat (3) @(negedge clk);
      chk(active === 1'b0 && io_ready === 1'b1, "active without record");
      startup(1'b0);
      for (int k = 0; k < 64; k++) begin
         idx = rnd() % 4;
         ent[k] = idx == 0 ? 8'h00 : idx == 1 ? 8'hFF : 8'h01 + 8'(rnd() % 64);
      end
      ent[0] = 8'h40;
      ent[1] = 8'h01;
      ent[2] = 8'h00;
      ent[3] = 8'hFF;
      wr_rec(8'h7E, 64, 4'b0100, 1'b0);
      wr_rec(8'h7F, 1, 4'b0010, 1'b0);
      wr_rec(8'h7F, 63, 4'b0010, 1'b0);
      wr_rec(8'h7F, 65, 4'b0010, 1'b0);
      wr_rec(8'h7F, 64, 4'b1000, 1'b1);
      chk(active === 1'b1, "active after record");
      rd_all(8'h7F);
      rd_all(8'h7E);
      wr_rec(8'h7F, 64, 4'b1000, 1'b0);
      bad = '{8'h41, 8'hFE, 8'h41 + 8'(rnd() % 190)};
      for (int v = 0; v < 3; v++) begin
         idx = rnd() % 64;
         ent[idx] = bad[v];
         wr_rec(8'h7F, 64, 4'b0001, 1'b0);
         ent[idx] = act[idx];
      end
      rd_all(8'h7F);
      for (int k = 0; k < 64; k++)
         acc(1'b1, k[5:0], 8'(rnd()));
      for (int k = 0; k < 64; k++)
         acc(1'b0, k[5:0], 8'h00);
      repeat (40) begin
         idx = rnd();
         acc(idx[8], idx[5:0], idx[23:16]);
      end
      startup(1'b1);
      @(posedge clk);
      feat <= 1'b0;
      repeat (2) @(negedge clk);
      chk(active === 1'b0, "active with feature off");
      acc(1'b1, 6'h02, 8'h5A);
      acc(1'b0, 6'h02, 8'h00);
      startup(1'b0);
      @(posedge clk);
      feat <= 1'b1;
      ent[5] = act[5] == 8'hFF ? 8'h01 : 8'hFF;
      wr_rec(8'h7F, 64, 4'b1000, 1'b1);
      acc(1'b0, 6'h05, 8'h00);
      pulse(1'b0);
      chk(active === 1'b1, "record lost on reset");
      rd_all(8'h7F);
      pulse(1'b1);
      chk(active === 1'b0, "active after power-on");
      print_verdict();
   end
endmodule
`default_nettype wire
